// ---- pkg/acq_pkg.sv ----
// Shared constants and types of the acquisition controller
package acq_pkg;
	localparam int DATA_W = 16;
	localparam int FIFO_AW = 10;
	localparam int FIFO_DEPTH = 1024;
	localparam logic [10:0] FIFO_FULL_LVL = 11'h400;
	localparam logic [10:0] FIFO_HALF_LVL = 11'h200;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_PACE = 8'h08;
	localparam logic [7:0] OFF_COUNT = 8'h0c;
	localparam logic [7:0] OFF_FIFO = 8'h10;
	localparam logic [7:0] OFF_ISTAT = 8'h14;
	localparam logic [7:0] OFF_IMASK = 8'h18;
	localparam logic [7:0] OFF_IOBASE = 8'h1c;
	// Control register fields
	localparam int CTRL_RST = 0;
	localparam int CTRL_CONV = 1;
	localparam int CTRL_DMA = 2;
	localparam int CTRL_REQ = 3;
	localparam int CTRL_CHAN = 5;
	localparam int CTRL_AO = 7;
	localparam int CTRL_OUTP = 8;
	localparam int CTRL_MUX = 9;
	localparam int CTRL_TRIG = 10;
	localparam int CTRL_SCAN = 11;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] PACE_RESET = 16'h0008;
	localparam logic [15:0] COUNT_RESET = 16'h0002;
	localparam logic [9:0] IOBASE_RESET = 10'h300;
	// Status register fields
	localparam int STAT_EMPTY = 0;
	localparam int STAT_HALF = 1;
	localparam int STAT_FULL = 2;
	localparam int STAT_DONE = 3;
	localparam int STAT_TRIG = 4;
	localparam int STAT_DREQ = 5;
	// Interrupt status bits
	localparam int INT_W = 4;
	localparam int INT_COUNT = 0;
	localparam int INT_FULL = 1;
	localparam int INT_HALF = 2;
	localparam int INT_TC = 3;
	// Timer reference derived from the system clock
	localparam int CLK_HZ = 25000000;
	localparam int TIMER_HZ = 8000000;
	localparam logic [5:0] TICK_STEP = 6'(TIMER_HZ / 1000000);
	localparam logic [5:0] TICK_MOD = 6'(CLK_HZ / 1000000);
	localparam logic [6:0] SCAN_125K = 7'(TIMER_HZ / 125000 - 1);
	localparam logic [6:0] SCAN_250K = 7'(TIMER_HZ / 250000 - 1);
	localparam logic [6:0] SCAN_500K = 7'(TIMER_HZ / 500000 - 1);
	localparam int TRIG_RESP_NS = 2000;
	localparam int TRIG_RESP_CYC = TRIG_RESP_NS * (CLK_HZ / 1000000) / 1000;
	localparam int PIN_W = 19;
	typedef enum logic [1:0] {
		REQ_FULL = 2'b00,
		REQ_HALF = 2'b01,
		REQ_NOTEMPTY = 2'b10,
		REQ_COUNT = 2'b11
	} dreq_t;
endpackage

// ---- pkg/fifo_mem_if.sv ----
// Port bundle between the controller and its sample memory
`timescale 1ns/1ps
`default_nettype none
interface fifo_mem_if;
	logic wrEn;
	logic [acq_pkg::FIFO_AW-1:0] wrAddr;
	logic [acq_pkg::DATA_W-1:0] wrData;
	logic rdEn;
	logic [acq_pkg::FIFO_AW-1:0] rdAddr;
	logic [acq_pkg::DATA_W-1:0] rdData;
	modport ctrl (output wrEn, wrAddr, wrData, rdEn, rdAddr, input rdData);
	modport mem (input wrEn, wrAddr, wrData, rdEn, rdAddr, output rdData);
endinterface
`default_nettype wire

// ---- logic/sample_mem.sv ----
// Sample storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module sample_mem
	import acq_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Memory port
	fifo_mem_if.mem port
);
	logic [DATA_W-1:0] store [FIFO_DEPTH];
	logic [DATA_W-1:0] rdData_q;

	always_ff @(posedge clk)
	begin
		if (port.wrEn)
			store[port.wrAddr] <= port.wrData;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rdData_q <= 16'h0000;
		else if (port.rdEn)
			rdData_q <= store[port.rdAddr];
	end

	assign port.rdData = rdData_q;
endmodule
`default_nettype wire

// ---- logic/acq_ctrl.sv ----
// Acquisition control: sample buffer, pacer, trigger, DMA and APB registers
//
// Function
// R01 - Buffer samples first-in first-out, depth 1024
// R02 - Pace converter starts by 16-bit divisor
// R03 - Count samples, flag when count reached
// R04 - Count 3..65536; terminal sets flag, gates starts
// R05 - Timer channels run from 8 MHz reference
// R06 - Scan clock selectable 125, 250, 500 kHz
// R07 - Trigger status flag within 2 us
// R08 - Analog output general or trigger threshold
// R09 - Decode eight 16-bit host registers
// R10 - Compare address bits 9..0, ignore higher
// R11 - Software picks programmed reads or DMA
// R12 - One DMA channel, selectable 5, 6, 7
// R13 - DMA request on one selected condition
// R14 - Board reset, FIFO flags, interrupt/DMA status
// R15 - Trigger source, timer period, count load
// R16 - Enables for outport, conversion, mux sequencing
// R17 - One interrupt, selectable among four sources
// R18 - Drop request when condition ends; no overfill
// R19 - Soft reset empties buffer, clears flags, disables (a trigger edge or interrupt event in the same cycle still sets its flag)
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module acq_ctrl
	import acq_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Converter side
	input wire logic adcValid,
	input wire logic [acq_pkg::DATA_W-1:0] adcData,
	output logic convStart,
	output logic scanClk,
	// Pins
	input wire logic trigIn,
	input wire logic dmaAckIn,
	input wire logic dmaTcIn,
	input wire logic [15:0] ioAddr,
	// DMA
	output logic [2:0] dmaDrq,
	output logic [acq_pkg::DATA_W-1:0] dmaData,
	// Host decode
	output logic ioSelect,
	output logic [2:0] ioRegIndex,
	// Function selects
	output logic aoThreshold,
	output logic outportEnable,
	output logic muxAutoSeq,
	// Interrupt
	output logic irq
);
	function automatic logic regHit(input logic [7:0] a, input logic [7:0] off);
		regHit = (a == off);
	endfunction

	fifo_mem_if memBus ();

	sample_mem u_mem (
		.clk(clk),
		.reset_n(reset_n),
		.port(memBus.mem)
	);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [PIN_W-1:0] pinRaw;
	logic [PIN_W-1:0] pin1_q;
	logic [PIN_W-1:0] pin2_q;
	logic [2:0] pinOld_q;
	logic trigRise;
	logic ackRise;
	logic tcRise;

	assign pinRaw = {trigIn, dmaAckIn, dmaTcIn, ioAddr};

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pin1_q <= '0;
			pin2_q <= '0;
			pinOld_q <= 3'h0;
		end
		else
		begin
			pin1_q <= pinRaw;
			pin2_q <= pin1_q;
			pinOld_q <= pin2_q[18:16];
		end
	end

	assign trigRise = pin2_q[18] & ~pinOld_q[2];
	assign ackRise = pin2_q[17] & ~pinOld_q[1];
	assign tcRise = pin2_q[16] & ~pinOld_q[0];

	////////////////////////////////////////////////////////////////////////
	// APB decode
	logic ack_q;
	logic apbFirst;
	logic apbDone;
	logic addrOk;
	logic selCtrl;
	logic selStat;
	logic selPace;
	logic selCount;
	logic selFifo;
	logic selIstat;
	logic selImask;
	logic selIobase;
	logic wrDone;

	assign selCtrl = regHit(paddr, OFF_CTRL);
	assign selStat = regHit(paddr, OFF_STAT);
	assign selPace = regHit(paddr, OFF_PACE);
	assign selCount = regHit(paddr, OFF_COUNT);
	assign selFifo = regHit(paddr, OFF_FIFO);
	assign selIstat = regHit(paddr, OFF_ISTAT);
	assign selImask = regHit(paddr, OFF_IMASK);
	assign selIobase = regHit(paddr, OFF_IOBASE);
	assign addrOk = selCtrl | selStat | selPace | selCount | selFifo
		| selIstat | selImask | selIobase; // R09
	// Two access cycles: first latches read data, second answers
	assign apbFirst = psel & penable & ~ack_q;
	assign apbDone = psel & penable & ack_q;
	assign pready = apbDone;
	assign pslverr = apbDone & ~addrOk;
	assign wrDone = apbDone & pwrite & addrOk;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ack_q <= 1'b0;
		else
			ack_q <= apbFirst;
	end

	////////////////////////////////////////////////////////////////////////
	// Software registers
	logic [15:0] ctrl_q;
	logic [15:0] pace_q;
	logic [9:0] iobase_q;
	logic [INT_W-1:0] imask_q;
	logic softRst;
	logic convEn;
	logic dmaMode;
	logic trigArmed;
	dreq_t reqSel;
	logic [1:0] chanSel;
	logic [1:0] scanSel;

	assign softRst = wrDone & selCtrl & pwdata[CTRL_RST]; // R14
	assign convEn = ctrl_q[CTRL_CONV]; // R16
	assign dmaMode = ctrl_q[CTRL_DMA]; // R11
	assign reqSel = dreq_t'(ctrl_q[CTRL_REQ+1:CTRL_REQ]);
	assign chanSel = ctrl_q[CTRL_CHAN+1:CTRL_CHAN];
	assign scanSel = ctrl_q[CTRL_SCAN+1:CTRL_SCAN];
	assign aoThreshold = ctrl_q[CTRL_AO]; // R08
	assign outportEnable = ctrl_q[CTRL_OUTP]; // R16
	assign muxAutoSeq = ctrl_q[CTRL_MUX]; // R16

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrl_q <= CTRL_RESET;
			pace_q <= PACE_RESET;
			iobase_q <= IOBASE_RESET;
			imask_q <= '0;
		end
		else if (softRst)
		begin
			ctrl_q <= CTRL_RESET; // R19
			imask_q <= '0; // R19
		end
		else if (wrDone)
		begin
			if (selCtrl)
				ctrl_q <= {pwdata[15:1], 1'b0};
			if (selPace)
				pace_q <= pwdata[15:0]; // R15
			if (selIobase)
				iobase_q <= pwdata[9:0];
			if (selImask)
				imask_q <= pwdata[INT_W-1:0]; // R17
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sample buffer pointers
	logic [FIFO_AW:0] wrPtr_q;
	logic [FIFO_AW:0] rdPtr_q;
	logic [FIFO_AW:0] level;
	logic fifoEmpty;
	logic fifoFull;
	logic fifoHalf;
	logic fifoWr;
	logic pioPop;
	logic dmaPop;
	logic pop;

	assign level = wrPtr_q - rdPtr_q;
	assign fifoEmpty = (level == '0);
	assign fifoFull = (level == FIFO_FULL_LVL);
	assign fifoHalf = (level >= FIFO_HALF_LVL);
	assign fifoWr = adcValid & convEn & ~fifoFull; // R18
	// Pops belong to one path only, chosen by transfer mode
	assign pioPop = apbFirst & ~pwrite & selFifo & ~dmaMode & ~fifoEmpty; // R11
	assign dmaPop = ackRise & dmaMode & ~fifoEmpty; // R11
	assign pop = pioPop | dmaPop;

	assign memBus.wrEn = fifoWr; // R01
	assign memBus.wrAddr = wrPtr_q[FIFO_AW-1:0];
	assign memBus.wrData = adcData;
	assign memBus.rdEn = pop; // R01
	assign memBus.rdAddr = rdPtr_q[FIFO_AW-1:0];
	assign dmaData = memBus.rdData;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end
		else if (softRst)
		begin
			wrPtr_q <= '0; // R19
			rdPtr_q <= '0; // R19
		end
		else
		begin
			if (fifoWr)
				wrPtr_q <= wrPtr_q + 1'b1;
			if (pop)
				rdPtr_q <= rdPtr_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timer reference, pacer and scan clock
	logic [5:0] acc_q;
	logic [5:0] accSum;
	logic tick;
	logic [15:0] paceCnt_q;
	logic paceWrap;
	logic pacingOn;
	logic convStart_q;
	logic [6:0] scanCnt_q;
	logic [6:0] scanLimit;
	logic scanClk_q;
	logic trigFlag_q;
	logic countDone_q;

	// Fractional accumulator: average 8 ticks per 25 clocks
	assign accSum = acc_q + TICK_STEP;
	assign tick = (accSum >= TICK_MOD); // R05
	assign paceWrap = (paceCnt_q <= 16'h0001);
	assign trigArmed = ~ctrl_q[CTRL_TRIG] | trigFlag_q; // R15
	assign pacingOn = convEn & ~countDone_q & trigArmed; // R04
	assign scanLimit = (scanSel == 2'h0) ? SCAN_125K :
		(scanSel == 2'h1) ? SCAN_250K : SCAN_500K; // R06
	assign convStart = convStart_q;
	assign scanClk = scanClk_q;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			acc_q <= 6'h00;
		else if (tick)
			acc_q <= accSum - TICK_MOD; // R05
		else
			acc_q <= accSum;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			paceCnt_q <= PACE_RESET;
			convStart_q <= 1'b0;
		end
		else
		begin
			convStart_q <= tick & paceWrap & pacingOn; // R02
			if (tick)
				paceCnt_q <= paceWrap ? pace_q : paceCnt_q - 1'b1; // R02
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			scanCnt_q <= 7'h00;
			scanClk_q <= 1'b0;
		end
		else
		begin
			scanClk_q <= tick & (scanCnt_q >= scanLimit); // R06
			if (tick)
				scanCnt_q <= (scanCnt_q >= scanLimit) ? 7'h00 : scanCnt_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sample counter and trigger flag
	logic [15:0] sampCnt_q;
	logic countEv;
	logic trigClr;

	// Loaded value is count minus one
	assign countEv = fifoWr & ~countDone_q & (sampCnt_q == 16'h0000); // R03
	assign trigClr = wrDone & selStat & pwdata[STAT_TRIG];

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sampCnt_q <= COUNT_RESET;
			countDone_q <= 1'b0;
		end
		else if (softRst)
			countDone_q <= 1'b0; // R19
		else if (wrDone & selCount)
		begin
			sampCnt_q <= pwdata[15:0]; // R15
			countDone_q <= 1'b0;
		end
		else if (countEv)
			countDone_q <= 1'b1; // R04
		else if (fifoWr & ~countDone_q)
			sampCnt_q <= sampCnt_q - 1'b1; // R03
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			trigFlag_q <= 1'b0;
		else if (trigRise)
			trigFlag_q <= 1'b1; // R07
		else if (softRst | trigClr)
			trigFlag_q <= 1'b0; // R19
	end

	////////////////////////////////////////////////////////////////////////
	// DMA request
	logic reqCond;
	logic dmaReqOn;

	assign reqCond = (reqSel == REQ_FULL) ? fifoFull :
		(reqSel == REQ_HALF) ? fifoHalf :
		(reqSel == REQ_NOTEMPTY) ? ~fifoEmpty :
		(countDone_q & ~fifoEmpty); // R13
	// Combinational so the request falls the cycle the cause ends
	assign dmaReqOn = dmaMode & reqCond; // R18
	assign dmaDrq[0] = dmaReqOn & (chanSel == 2'h0); // R12
	assign dmaDrq[1] = dmaReqOn & (chanSel == 2'h1); // R12
	assign dmaDrq[2] = dmaReqOn & (chanSel == 2'h2); // R12

	////////////////////////////////////////////////////////////////////////
	// Interrupt status
	logic [INT_W-1:0] istat_q;
	logic [INT_W-1:0] intEv;
	logic [INT_W-1:0] intClr;
	logic fullOld_q;
	logic halfOld_q;

	assign intEv[INT_COUNT] = countEv;
	assign intEv[INT_FULL] = fifoFull & ~fullOld_q;
	assign intEv[INT_HALF] = fifoHalf & ~halfOld_q;
	assign intEv[INT_TC] = tcRise;
	assign intClr = (wrDone & selIstat) ? pwdata[INT_W-1:0] : '0;
	assign irq = |(istat_q & imask_q); // R17

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			fullOld_q <= 1'b0;
			halfOld_q <= 1'b0;
		end
		else
		begin
			fullOld_q <= fifoFull;
			halfOld_q <= fifoHalf;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < INT_W; gi++)
		begin : g_int
			always_ff @(posedge clk or negedge reset_n)
			begin
				if (!reset_n)
					istat_q[gi] <= 1'b0;
				else if (intEv[gi])
					istat_q[gi] <= 1'b1; // R17
				else if (softRst | intClr[gi])
					istat_q[gi] <= 1'b0;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Host address decode
	logic ioSel_q;
	logic [2:0] ioIdx_q;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ioSel_q <= 1'b0;
			ioIdx_q <= 3'h0;
		end
		else
		begin
			ioSel_q <= (pin2_q[9:3] == iobase_q[9:3]); // R10
			ioIdx_q <= pin2_q[2:0]; // R09
		end
	end

	assign ioSelect = ioSel_q;
	assign ioRegIndex = ioIdx_q;

	////////////////////////////////////////////////////////////////////////
	// Read data
	logic [15:0] statWord;
	logic [15:0] rdMux;
	logic [31:0] regRd_q;
	logic fifoTook_q;

	assign statWord = {10'h000, dmaReqOn, trigFlag_q, countDone_q,
		fifoFull, fifoHalf, fifoEmpty}; // R14
	assign rdMux = selCtrl ? ctrl_q :
		selStat ? statWord :
		selPace ? pace_q :
		selCount ? sampCnt_q :
		selIstat ? {12'h000, istat_q} :
		selImask ? {12'h000, imask_q} :
		selIobase ? {6'h00, iobase_q} : 16'h0000;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			regRd_q <= 32'h00000000;
			fifoTook_q <= 1'b0;
		end
		else if (apbFirst)
		begin
			regRd_q <= {16'h0000, rdMux};
			fifoTook_q <= pioPop;
		end
	end

	// Empty buffer or DMA mode reads as zero
	assign prdata = fifoTook_q ? {16'h0000, memBus.rdData} : regRd_q;
endmodule
`default_nettype wire

// ---- tb/acq_ctrl_asserts.sv ----
// Port-level checks of the acquisition controller
`timescale 1ns/1ps
`default_nettype none
module acq_ctrl_asserts
	import acq_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// APB
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Outputs watched
	input wire logic convStart,
	input wire logic scanClk,
	input wire logic [2:0] dmaDrq,
	input wire logic irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence setupThenAccess;
		psel && !penable ##1 psel && penable;
	endsequence
	wire unmapped = (paddr[1:0] != 2'b00) || (paddr > OFF_IOBASE);
	a_ready_first_low: assert property (setupThenAccess |-> !pready)
		else $error("pready in first access cycle");
	a_ready_second: assert property (setupThenAccess |=> pready)
		else $error("pready missing in second access cycle");
	a_err_decode: assert property (pready |-> pslverr == unmapped)
		else $error("pslverr does not match decode");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_err_reads_zero: assert property (pready && !pwrite && pslverr |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
		else $error("upper read bits not zero");
	a_one_channel: assert property ($onehot0(dmaDrq))
		else $error("more than one request line");
	a_start_pulse: assert property (convStart |=> !convStart)
		else $error("start pulse longer than one cycle");
	a_scan_spacing: assert property (scanClk |=> !scanClk [*8])
		else $error("scan pulses too close");
	a_soft_reset: assert property (pready && pwrite && paddr == OFF_CTRL && pwdata[CTRL_RST]
		|=> dmaDrq == 3'b000 && !irq)
		else $error("soft reset left request or interrupt");
endmodule
bind acq_ctrl acq_ctrl_asserts chk_i (.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .convStart(convStart), .scanClk(scanClk), .dmaDrq(dmaDrq), .irq(irq));
`default_nettype wire

// ---- tb/dma_host_model.sv ----
// Host DMA controller: acknowledges requests and counts words taken
`timescale 1ns/1ps
`default_nettype none
module dma_host_model
#(
	parameter int GAP = 2,
	parameter int TC_AT = 3
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Device side
	input wire logic [2:0] dmaDrq,
	input wire logic [15:0] dmaData,
	output logic dmaAckIn,
	output logic dmaTcIn,
	// Bench side
	output logic [7:0] nTaken,
	output logic [15:0] lastWord
);
	initial
	begin
		dmaAckIn = 1'b0;
		dmaTcIn = 1'b0;
		nTaken = 8'h00;
		lastWord = 16'h0000;
	end
	always
	begin
		@(posedge clk);
		if (reset_n && dmaDrq != 3'b000)
		begin
			dmaAckIn <= 1'b1;
			repeat (2) @(posedge clk);
			dmaAckIn <= 1'b0;
			// Word lands a few cycles after the acknowledge edge
			repeat (3) @(posedge clk);
			lastWord <= dmaData;
			nTaken <= nTaken + 8'h01;
			dmaTcIn <= (32'(nTaken) + 1 == TC_AT);
			repeat (GAP + 2) @(posedge clk);
			dmaTcIn <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- tb/acq_ctrl_tb_top.sv ----
// Self-checking bench of the acquisition controller
`timescale 1ns/1ps
`default_nettype none
module acq_ctrl_tb_top;
	import acq_pkg::*;
	logic clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
	logic adcValid, trigIn, dmaAckIn, dmaTcIn, convStart, scanClk, ioSelect, irq, ao, outp, mux;
	logic [7:0] paddr, nTaken;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] adcData, ioAddr, dmaData, lastWord;
	logic [2:0] dmaDrq, ioRegIndex;
	int n_fail = 0;
	int n_checks = 0;
	int i;
	acq_ctrl uut (.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.adcValid(adcValid), .adcData(adcData), .convStart(convStart), .scanClk(scanClk),
		.trigIn(trigIn), .dmaAckIn(dmaAckIn), .dmaTcIn(dmaTcIn), .ioAddr(ioAddr),
		.dmaDrq(dmaDrq), .dmaData(dmaData), .ioSelect(ioSelect), .ioRegIndex(ioRegIndex),
		.aoThreshold(ao), .outportEnable(outp), .muxAutoSeq(mux), .irq(irq));
	dma_host_model host (.clk(clk), .reset_n(reset_n), .dmaDrq(dmaDrq), .dmaData(dmaData),
		.dmaAckIn(dmaAckIn), .dmaTcIn(dmaTcIn), .nTaken(nTaken), .lastWord(lastWord));
	////////////////////////////////////////////////////////////////////////////////
	task close_out;
		if (n_fail == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Request held until pready is seen high at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [15:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (k >= 20)
		begin
			n_fail++;
			close_out();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Cycles between two scan pulses, counted from the first one seen
	task scan_gap(input int exp);
		int k;
		for (k = 0; k < 300 && scanClk !== 1'b1; k++) @(negedge clk);
		@(negedge clk);
		for (k = 1; k < 300 && scanClk !== 1'b1; k++) @(negedge clk);
		chk(k, exp);
	endtask
	task push(input logic [15:0] d);
		@(posedge clk);
		adcValid <= 1'b1;
		adcData <= d;
		@(posedge clk);
		adcValid <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial
	begin
		{reset_n, psel, penable, pwrite, adcValid, trigIn} = 6'h00;
		{paddr, pwdata, adcData, ioAddr} = 72'h0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		apb(0, OFF_CTRL, 0); chk(rd, 32'h0);
		apb(0, OFF_PACE, 0); chk(rd, 32'h8);
		apb(0, OFF_COUNT, 0); chk(rd, 32'h2);
		apb(0, OFF_IOBASE, 0); chk(rd, 32'h300);
		apb(0, OFF_STAT, 0); chk(rd[4:0], 5'h01);
		apb(0, 8'h20, 0); chk(rd, 32'h0);
		chk(32'(err), 32'h1);
		scan_gap(CLK_HZ / 125000);
		// Conversion on, request channel off so the bus stays quiet
		apb(1, OFF_CTRL, 16'h0062);
		for (i = 0; i < 200 && convStart !== 1'b1; i++) @(negedge clk);
		chk(convStart, 1'b1);
		for (i = 0; i < 1026; i++) push(16'h0100 + 16'(i));
		apb(0, OFF_STAT, 0); chk(rd[4:0], 5'h0e);
		// Count reached: no further start pulse may appear
		for (i = 0; i < 200 && convStart !== 1'b1; i++) @(negedge clk);
		chk(convStart, 1'b0);
		apb(0, OFF_ISTAT, 0); chk(rd, 32'h7);
		apb(1, OFF_IMASK, 16'h0002); @(negedge clk); chk(irq, 1'b1);
		apb(1, OFF_ISTAT, 16'h0002); @(negedge clk); chk(irq, 1'b0);
		apb(0, OFF_ISTAT, 0); chk(rd, 32'h5);
		apb(1, OFF_ISTAT, 16'h000f);
		for (i = 0; i < 1024; i++)
		begin
			apb(0, OFF_FIFO, 0);
			chk(rd, 32'h0100 + i);
		end
		apb(0, OFF_FIFO, 0); chk(rd, 32'h0);
		apb(0, OFF_STAT, 0); chk(rd[2:0], 3'h1);
		@(posedge clk);
		trigIn <= 1'b1;
		repeat (50) @(posedge clk);
		trigIn <= 1'b0;
		apb(0, OFF_STAT, 0); chk(rd[4], 1'b1);
		apb(1, OFF_STAT, 16'h0010);
		apb(0, OFF_STAT, 0); chk(rd[4], 1'b0);
		apb(1, OFF_CTRL, 16'h0800);
		scan_gap(CLK_HZ / 250000);
		apb(1, OFF_CTRL, 16'h1000);
		scan_gap(CLK_HZ / 500000);
		apb(1, OFF_CTRL, 16'h0380); @(negedge clk); chk({ao, outp, mux}, 3'h7);
		apb(1, OFF_CTRL, 16'h0001); @(negedge clk); chk({ao, outp, mux}, 3'h0);
		apb(0, OFF_CTRL, 0); chk(rd, 32'h0);
		// DMA on channel 6, first on the full condition, which stays false
		apb(1, OFF_CTRL, 16'h0026);
		for (i = 0; i < 3; i++) push(16'ha000 + 16'(i));
		@(negedge clk); chk(dmaDrq, 3'b000);
		apb(0, OFF_FIFO, 0); chk(rd, 32'h0);
		apb(1, OFF_CTRL, 16'h0036); @(negedge clk); chk(dmaDrq, 3'b010);
		for (i = 0; i < 300 && nTaken !== 8'h03; i++) @(negedge clk);
		chk(lastWord, 16'ha002);
		repeat (3) @(negedge clk);
		chk(dmaDrq, 3'b000);
		apb(0, OFF_ISTAT, 0); chk(rd[INT_TC], 1'b1);
		ioAddr <= 16'hff05;
		repeat (5) @(negedge clk);
		chk({ioSelect, ioRegIndex}, 4'hd);
		@(posedge clk);
		ioAddr <= 16'h0105;
		repeat (5) @(negedge clk);
		chk(ioSelect, 1'b0);
		close_out();
	end
endmodule
`default_nettype wire
